// ### design/scsp_pkg.sv
// shared constants, sample carrier and fill states of the converter output pipeline
package scsp_pkg;
   // code widths of the two flash stages and of the output word
   localparam int unsigned COARSE_W   = 5;
   localparam int unsigned FINE_W     = 6;
   localparam int unsigned WORD_W     = 10;
   localparam int unsigned TAPS       = 32;
   localparam int unsigned SUM_W      = WORD_W + 1;
   localparam int unsigned FIFO_W     = WORD_W + 1;
   localparam int unsigned FIFO_DEPTH = 32;
   // pins passed through the input synchroniser
   localparam int unsigned PIN_W      = 1 + COARSE_W + FINE_W + 2;
   // clamp codes at either end of the range
   localparam logic [WORD_W-1:0] WORD_MAX = 10'h3ff;
   localparam logic [WORD_W-1:0] WORD_MIN = 10'h000;
   localparam logic [WORD_W-1:0] WORD_RST = 10'h000;
   localparam logic [TAPS-1:0]   TAP_ONE  = 32'h0000_0001;
   localparam logic [TAPS-1:0]   TAP_RST  = 32'h0000_0000;
   // position of the coarse code inside the sum: one coarse step is 32 fine steps
   localparam int unsigned COARSE_SHIFT = FINE_W - 1;
   // ref clock period; encode must stay at or below a quarter of this rate
   localparam int unsigned REF_PERIOD_NS = 100;

   // one converted result: word plus over-range flag
   typedef struct packed {
      logic              over;
      logic [WORD_W-1:0] word;
   } scsp_sample_s;

   // pipeline fill tracking after reset
   typedef enum logic [1:0] {
      ST_FILL0,
      ST_FILL1,
      ST_RUN
   } scsp_fill_e;
endpackage

// ### design/scsp_sync.sv
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ns
module scsp_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         ref_clk_i,
   input  wire logic         rstn_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // first stage is read only by the second stage
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (ce_i) begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule

// ### design/scsp_fifo.sv
// result fifo with valid/ready on both sides
`timescale 1ns/1ns
module scsp_fifo #(
   parameter int unsigned W     = 11,
   parameter int unsigned DEPTH = 32
) (
   input  wire logic         ref_clk_i,
   input  wire logic         rstn_i,
   input  wire logic         ce_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic      [W-1:0] out_data_o
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [W-1:0] mem_q [DEPTH];
   logic [AW:0]  wr_q;
   logic [AW:0]  rd_q;
   wire          full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   wire          empty = (wr_q == rd_q);
   wire          push  = in_valid_i && !full;
   wire          pop   = out_ready_i && !empty;

   assign in_ready_o  = !full;
   assign out_valid_o = !empty;
   assign out_data_o  = mem_q[rd_q[AW-1:0]];

   // storage array, written only on an accepted push
   always_ff @(posedge ref_clk_i) begin
      if (ce_i && push) begin
         mem_q[wr_q[AW-1:0]] <= in_data_i;
      end
   end

   // pointers carry one wrap bit for honest full and empty
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         wr_q <= '0;
         rd_q <= '0;
      end else if (ce_i) begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop)  rd_q <= rd_q + 1'b1;
      end
   end
endmodule

// ### design/scsp_core.sv
// two-step converter digital pipeline: coarse select, error-corrected decode, latched output
`timescale 1ns/1ns
//
// Contract
// - every rising encode edge holds the input and starts a new conversion.
// - a sample appears two and a half encode periods after its rising edge when the fifo is empty and ready is high.
// - the output word updates on the falling encode edge.
// - each result is one ten-bit parallel word, all bits updated together.
// - the coarse result selects exactly one of thirty-two residue taps.
// - five coarse bits join six fine bits; top fine bit corrects the coarse code.
// - over-range flag high when input lies beyond either end by one step.
// - output bit nine is most significant, bit zero least significant.
module scsp_core (
   input  wire logic                          ref_clk_i,
   input  wire logic                          rstn_i,
   input  wire logic                          ce_i,
   input  wire logic                          encode_i,
   input  wire logic [scsp_pkg::COARSE_W-1:0] coarse_i,
   input  wire logic [scsp_pkg::FINE_W-1:0]   fine_i,
   input  wire logic                          above_i,
   input  wire logic                          below_i,
   input  wire logic                          out_ready_i,
   output logic      [scsp_pkg::TAPS-1:0]     tap_sel_o,
   output logic      [scsp_pkg::WORD_W-1:0]   sample_o,
   output logic                               overrange_o,
   output logic                               sample_valid_o,
   output logic                               fifo_ready_o,
   output logic                               dropped_o
);
   localparam int unsigned CW = scsp_pkg::COARSE_W;
   localparam int unsigned FW = scsp_pkg::FINE_W;
   localparam int unsigned WW = scsp_pkg::WORD_W;
   localparam int unsigned SW = scsp_pkg::SUM_W;

   // encode, code and range pins pass two flops before any logic reads them; out_ready_i is read directly
   logic [scsp_pkg::PIN_W-1:0] pins_s;
   scsp_sync #(
      .W (scsp_pkg::PIN_W)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .rstn_i    (rstn_i),
      .ce_i      (ce_i),
      .async_i   ({encode_i, coarse_i, fine_i, above_i, below_i}),
      .sync_o    (pins_s)
   );

   // unpack synchronised pins
   wire          enc_s    = pins_s[scsp_pkg::PIN_W-1];
   wire [CW-1:0] coarse_s = pins_s[FW+2 +: CW];
   wire [FW-1:0] fine_s   = pins_s[2 +: FW];
   wire          above_s  = pins_s[1];
   wire          below_s  = pins_s[0];

   logic                  enc_q;
   logic [CW-1:0]         coarse_q;
   logic                  above_q;
   logic                  below_q;
   logic [scsp_pkg::TAPS-1:0] tap_q;
   scsp_pkg::scsp_sample_s dec_q;
   scsp_pkg::scsp_sample_s out_q;
   scsp_pkg::scsp_fill_e   fill_q;
   scsp_pkg::scsp_fill_e   fill_d;
   logic                  valid_q;
   logic                  drop_q;

   // encode edge detection on the synchronised level
   wire enc_rise = enc_s && !enc_q;
   wire enc_fall = !enc_s && enc_q;

   // fine code adds to the shifted coarse code; its top bit carries into the coarse field
   wire [SW-1:0] sum = SW'({coarse_q, {scsp_pkg::COARSE_SHIFT{1'b0}}}) + SW'(fine_s);
   wire          sum_hi   = sum[SW-1] || above_q;
   wire [WW-1:0] word_d   = sum_hi  ? scsp_pkg::WORD_MAX :
                            below_q ? scsp_pkg::WORD_MIN : sum[WW-1:0];
   wire          over_d   = sum_hi || below_q;

   // fifo between decode and the output latch
   wire                    push = enc_rise && (fill_q == scsp_pkg::ST_RUN);
   wire                    pop  = enc_fall && out_ready_i;
   wire                    fifo_in_ready;
   wire                    fifo_out_valid;
   wire [scsp_pkg::FIFO_W-1:0] fifo_out;
   scsp_fifo #(
      .W     (scsp_pkg::FIFO_W),
      .DEPTH (scsp_pkg::FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_i   (ref_clk_i),
      .rstn_i      (rstn_i),
      .ce_i        (ce_i),
      .in_valid_i  (push),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (dec_q),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (pop),
      .out_data_o  (fifo_out)
   );

   // fill state: results are pushed only once two stages hold real samples
   always_comb begin
      fill_d = fill_q;
      case (fill_q)
         scsp_pkg::ST_FILL0: if (enc_rise) fill_d = scsp_pkg::ST_FILL1;
         scsp_pkg::ST_FILL1: if (enc_rise) fill_d = scsp_pkg::ST_RUN;
         scsp_pkg::ST_RUN:   fill_d = scsp_pkg::ST_RUN;
         default:            fill_d = scsp_pkg::ST_FILL0;
      endcase
   end

   // edge history and fill state
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         enc_q  <= 1'b0;
         fill_q <= scsp_pkg::ST_FILL0;
      end else if (ce_i) begin
         enc_q  <= enc_s;
         fill_q <= fill_d;
      end
   end

   // rising edge: hold coarse result and drive one-hot tap, decode the previous sample
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         coarse_q <= '0;
         above_q  <= 1'b0;
         below_q  <= 1'b0;
         tap_q    <= scsp_pkg::TAP_RST;
         dec_q    <= '0;
      end else if (ce_i && enc_rise) begin
         coarse_q <= coarse_s;
         above_q  <= above_s;
         below_q  <= below_s;
         tap_q    <= scsp_pkg::TAP_ONE << coarse_s;
         dec_q    <= '{over: over_d, word: word_d};
      end
   end

   // falling edge: whole word and flag latched together from the fifo head
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         out_q   <= '{over: 1'b0, word: scsp_pkg::WORD_RST};
         valid_q <= 1'b0;
      end else if (ce_i && pop) begin
         if (fifo_out_valid) begin
            out_q <= fifo_out;
         end
         valid_q <= fifo_out_valid;
      end
   end

   // sticky flag: a result was lost because the fifo was full
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         drop_q <= 1'b0;
      end else if (ce_i && push && !fifo_in_ready) begin
         drop_q <= 1'b1;
      end
   end

   assign tap_sel_o      = tap_q;
   assign sample_o       = out_q.word;
   assign overrange_o    = out_q.over;
   assign sample_valid_o = valid_q;
   assign fifo_ready_o   = fifo_in_ready;
   assign dropped_o      = drop_q;
endmodule

// ### tb/scsp_capture_model.sv
// far-side capture logic: free-running encode clock and capture ready
`timescale 1ns/1ns
module scsp_capture_model #(
   parameter int unsigned HALF = 5
) (
   input  wire logic ref_clk_i,
   input  wire logic stall_i,
   output logic      encode_o,
   output logic      out_ready_o
);
   int unsigned cnt = 0;
   // equal phases, never paused, so the hold stages stay in range
   assign encode_o = (cnt < HALF);
   initial out_ready_o = 1'b1;
   // ready moves only with a rise, so it is steady across the popping fall
   always @(negedge ref_clk_i) begin
      cnt <= (cnt == 2 * HALF - 1) ? 0 : cnt + 1;
      if (cnt == 2 * HALF - 1) out_ready_o <= !stall_i;
   end
endmodule

// ### tb/scsp_props.sv
// port checker of the converter pipeline
`timescale 1ns/1ns
module scsp_props (
   input wire logic        ref_clk_i,
   input wire logic        rstn_i,
   input wire logic        encode_i,
   input wire logic [31:0] tap_sel_o,
   input wire logic [9:0]  sample_o,
   input wire logic        overrange_o,
   input wire logic        sample_valid_o,
   input wire logic        fifo_ready_o,
   input wire logic        dropped_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   // taps follow encode rises, results follow encode falls
   a_tap_onehot: assert property ($onehot0(tap_sel_o))
      else $error("tap not onehot");
   a_tap_on_rise: assert property ($changed(tap_sel_o) |-> $past(encode_i, 2))
      else $error("tap moved late");
   a_tap_after_rise: assert property ($rose(encode_i) |-> ##6 tap_sel_o != 32'h0)
      else $error("no tap");
   a_word_on_fall: assert property ($changed(sample_o) |-> !$past(encode_i, 2))
      else $error("word moved early");
   a_valid_on_fall: assert property ($changed(sample_valid_o) |-> !$past(encode_i, 2))
      else $error("valid moved early");
   a_clamp_ends: assert property (sample_valid_o && overrange_o |->
      sample_o == 10'h3ff || sample_o == 10'h000) else $error("no clamp");
   a_drop_sticky: assert property (dropped_o |=> dropped_o)
      else $error("drop cleared");
   a_drop_cause: assert property ($rose(dropped_o) |-> !$past(fifo_ready_o))
      else $error("drop not full");
   c_drop: cover property ($rose(dropped_o));
   c_clamp: cover property (sample_valid_o && overrange_o);
   c_word: cover property ($changed(sample_o));
endmodule
bind scsp_core scsp_props u_props (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .encode_i(encode_i),
   .tap_sel_o(tap_sel_o), .sample_o(sample_o), .overrange_o(overrange_o),
   .sample_valid_o(sample_valid_o), .fifo_ready_o(fifo_ready_o), .dropped_o(dropped_o));

// ### tb/test_sampled_converter_output_pipeline.sv
// self-checking bench of the converter pipeline
`timescale 1ns/1ns
module test_sampled_converter_output_pipeline;
   logic        ref_clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        stall = 1'b0;
   logic        enc_q = 1'b0;
   logic        rdy_f = 1'b0;
   logic        drop_x = 1'b0;
   logic [12:0] pins = 13'h07c0;
   logic        encode_i, out_ready_i, overrange_o, sample_valid_o, fifo_ready_o, dropped_o;
   logic [31:0] tap_sel_o;
   logic [9:0]  sample_o;
   logic [6:0]  c1, c2;
   logic [5:0]  f1;
   int          n_errors = 0;
   int          n_compared = 0;
   int          n_rise = 0;
   int          rst_cnt = 10;
   int          cyc = 0;
   logic [12:0] cor [7] = '{13'h07c0, 13'h07ff, 13'h0820, 13'h1f80, 13'h003f, 13'h07c0, 13'h001f};
   scsp_pkg::scsp_sample_s q [$];
   scsp_capture_model #(.HALF(5)) u_far (.ref_clk_i(ref_clk_i), .stall_i(stall),
      .encode_o(encode_i), .out_ready_o(out_ready_i));
   scsp_core DUT (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .encode_i(encode_i),
      .coarse_i(pins[10:6]), .fine_i(pins[5:0]), .above_i(pins[12]), .below_i(pins[11]),
      .out_ready_i(out_ready_i), .tap_sel_o(tap_sel_o), .sample_o(sample_o),
      .overrange_o(overrange_o), .sample_valid_o(sample_valid_o),
      .fifo_ready_o(fifo_ready_o), .dropped_o(dropped_o));
   // expected result: one coarse step is 32 fine steps, clamped at both ends
   function automatic scsp_pkg::scsp_sample_s calc(logic [6:0] abc, logic [5:0] f);
      logic [10:0] s;
      s = {1'b0, abc[4:0], 5'h00} + {5'h00, f};
      if (s > 11'h3ff || abc[6]) return {1'b1, 10'h3ff};
      if (abc[5]) return {1'b1, 10'h000};
      return {1'b0, s[9:0]};
   endfunction
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (e !== g) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic complete_run();
      if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // bookkeeping one cycle after each encode edge
   task automatic step();
      logic [31:0] r;
      r = $urandom;
      if (rst_cnt > 0) rst_cnt--;
      if (encode_i && !enc_q && rstn_i && rst_cnt == 0) begin
         if (rdy_f) chk("valid", q.size() != 0, sample_valid_o);
         if (rdy_f && q.size() != 0) chk("word", q.pop_front(), {overrange_o, sample_o});
         chk("dropped", drop_x, dropped_o);
         chk("fifo_ready", q.size() != 32, fifo_ready_o);
         if (n_rise >= 2 && q.size() == 32) drop_x = 1'b1;
         else if (n_rise >= 2) q.push_back(calc(c2, f1));
         c2 = c1;
         c1 = pins[12:6];
         f1 = pins[5:0];
         n_rise++;
         stall <= (n_rise >= 20 && n_rise < 60) || (n_rise < 20 && r[9:8] == 2'b00);
      end
      if (!encode_i && enc_q) begin
         if (rstn_i && n_rise > 0) chk("tap_sel", 32'h1 << pins[10:6], tap_sel_o);
         if (!rstn_i) chk("reset", 32'h2, {tap_sel_o != 0, sample_o, overrange_o,
            sample_valid_o, fifo_ready_o, dropped_o});
         if (!rstn_i && rst_cnt == 0) rstn_i <= 1'b1;
         rdy_f = out_ready_i;
         pins <= (n_rise < 7) ? cor[n_rise] : {r[2:0] == 3'h0, r[5:3] == 3'h0, r[16:6]};
      end
      enc_q = encode_i;
   endtask
   // clock and a cycle ceiling against a hung run
   initial forever #50 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         n_errors++;
         complete_run();
      end
   end
   // main sequence with a second reset in mid-run
   initial begin
      void'($urandom(32'hf4e0d810));
      repeat (1600) begin
         @(negedge ref_clk_i);
         if (cyc == 1000) begin
            rstn_i <= 1'b0;
            rst_cnt = 10;
            q.delete();
            n_rise = 0;
            drop_x = 1'b0;
            rdy_f = 1'b0;
         end
         step();
      end
      complete_run();
   end
endmodule
